// ---- design/trig_pkg.sv ----
// Notes on behaviour
// R1 - edge detector fires on rising, falling or either edge of the chosen source
// R2 - auto mode makes its own trigger when no real event comes in time
// R3 - single mode takes one trigger then stops until a new run command
// R4 - holdoff is programmable; a command loads the smallest holdoff
// R5 - delay by time waits 4 ns to 10 s after the first event
// R6 - delay by event counts 1 to 65535 events after the first event
// R7 - a command loads the smallest delay time into the delay setting
// R8 - pulse width is measured against a reference of 4 ns to 10 s
// R9 - pulse width fires when longer, shorter, equal or unequal holds
// R10 - logic family preset loads the digital threshold value
// R11 - ac, hf and lf reject coupling are void on a digital source
// R12 - set to half puts the level at mid amplitude of the source
// R13 - normal mode triggers only on real events, never internally
// R14 - after a trigger, events are ignored until holdoff ends
package trig_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_NS       = 50;
  localparam longint NS_PER_S     = 1_000_000_000;
  localparam longint T_MIN_NS     = 4;
  localparam longint T_MAX_S      = 10;
  localparam longint HOLD_MIN_NS  = 100;
  localparam longint AUTO_WAIT_NS = 100_000_000;
  localparam logic [27:0] T_MIN_CYC    = 28'((T_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [27:0] T_MAX_CYC    = 28'((T_MAX_S * NS_PER_S) / CLK_NS);
  localparam logic [27:0] HOLD_MIN_CYC = 28'((HOLD_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int          AUTO_DEF_CYC = int'(AUTO_WAIT_NS / CLK_NS);
  localparam logic [15:0] EVT_MIN      = 16'h0001;

  // ----------------------------------------
  // register offsets and command bits
  // ----------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_HOLD  = 8'h08;
  localparam logic [7:0] A_DLY   = 8'h0c;
  localparam logic [7:0] A_EVT   = 8'h10;
  localparam logic [7:0] A_PWREF = 8'h14;
  localparam logic [7:0] A_LEVEL = 8'h18;
  localparam logic [7:0] A_THR   = 8'h1c;
  localparam logic [7:0] A_STAT  = 8'h20;
  localparam int C_RUN      = 0;
  localparam int C_STOP     = 1;
  localparam int C_HOLD_MIN = 2;
  localparam int C_DLY_MIN  = 3;
  localparam int C_HALF     = 4;
  localparam int C_PRESET   = 5;

  // ----------------------------------------
  // reset values and preset thresholds (mv)
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [15:0] P_TTL     = 16'h0578;
  localparam logic [15:0] P_CMOS50  = 16'h09c4;
  localparam logic [15:0] P_CMOS33  = 16'h0672;
  localparam logic [15:0] P_CMOS25  = 16'h04e2;
  localparam logic [15:0] P_ECL     = 16'hfaec;
  localparam logic [15:0] P_PECL    = 16'h0e74;
  localparam logic [15:0] P_ZERO    = 16'h0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_AUTO, MODE_NORMAL, MODE_SINGLE} mode_t;
  typedef enum logic [1:0] {SLOPE_RISE, SLOPE_FALL, SLOPE_EITHER} slope_t;
  typedef enum logic [1:0] {PW_GT, PW_LT, PW_EQ, PW_NE} pw_cond_t;
  typedef enum logic [2:0] {CPL_DC, CPL_AC, CPL_HF, CPL_LF, CPL_NOISE} cpl_t;
  typedef enum logic [2:0] {ST_STOP, ST_ARMED, ST_DLY_T, ST_DLY_E, ST_HOLD} st_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0]  preset;
    logic [2:0]  coupling;
    logic [4:0]  src;
    logic        pw_pos;
    pw_cond_t    pw_cond;
    logic        pw_en;
    logic        dly_evt;
    logic        dly_en;
    slope_t      slope;
    mode_t       mode;
  } ctrl_t;

  // sources 16..31 are the digital inputs
  function automatic logic is_dig(input logic [4:0] src);
    return src[4];
  endfunction

  function automatic logic [27:0] clamp_t(input logic [31:0] v, input logic [27:0] lo);
    if (v < {4'h0, lo}) return lo;
    if (v > {4'h0, T_MAX_CYC}) return T_MAX_CYC;
    return v[27:0];
  endfunction

endpackage

// ---- design/edge_pick.sv ----
`timescale 1ns/10ps
module edge_pick import trig_pkg::*; (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // source level and slope choice
  input  wire logic lvl,
  input  slope_t    slope,
  // qualified edge
  output logic      fire
);

  logic prev_r;
  logic prev_nxt;

  // R1 slope select
  always_comb begin
    prev_nxt = lvl;
    case (slope)
      SLOPE_RISE:   fire = lvl & ~prev_r;
      SLOPE_FALL:   fire = ~lvl & prev_r;
      SLOPE_EITHER: fire = lvl ^ prev_r;
      default:      fire = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prev_r <= 1'b0;
    else        prev_r <= prev_nxt;
  end

  // first edge after reset has no true previous level, so it is left out
  AST_EDGE_DIR: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (fire && $past(rst_n)) |-> ((slope != SLOPE_RISE) || (lvl && !$past(lvl)))
         && ((slope != SLOPE_FALL) || (!lvl && $past(lvl))))
    else $error("edge fired against the chosen slope");

endmodule

// ---- design/pulse_width.sv ----
`timescale 1ns/10ps
module pulse_width import trig_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // source and settings
  input  wire logic        lvl,
  input  wire logic        pos,
  input  pw_cond_t         cond,
  input  wire logic [27:0] refw,
  // width condition met
  output logic             fire
);

  logic        act;
  logic        prev_r, prev_nxt;
  logic [27:0] cnt_r, cnt_nxt;
  logic        fire_r, fire_nxt;

  assign act  = pos ? lvl : ~lvl;
  assign fire = fire_r;

  // R8 measure width
  always_comb begin
    prev_nxt = act;
    fire_nxt = 1'b0;
    cnt_nxt  = cnt_r;
    if (act) begin
      if (!prev_r) cnt_nxt = 28'h1;
      else if (cnt_r != 28'hfff_ffff) cnt_nxt = cnt_r + 28'h1;
    end else if (prev_r) begin
      // R9 compare at end
      case (cond)
        PW_GT:   fire_nxt = cnt_r > refw;
        PW_LT:   fire_nxt = cnt_r < refw;
        PW_EQ:   fire_nxt = cnt_r == refw;
        PW_NE:   fire_nxt = cnt_r != refw;
        default: fire_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      cnt_r  <= 28'h0;
      fire_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      fire_r <= fire_nxt;
    end
  end

  sequence s_pulse_end;
    prev_r && !act;
  endsequence

  AST_PW_SHORT: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (s_pulse_end ##0 (cond == PW_LT && cnt_r < refw)) |=> fire)
    else $error("shorter pulse did not fire");

  AST_PW_ONLY_END: assert property (@(posedge clk) disable iff (!rst_n) // R9
    fire |-> $past(prev_r) && !$past(act))
    else $error("width fired away from a pulse end");

endmodule

// ---- design/trig_qual.sv ----
`timescale 1ns/10ps
module trig_qual import trig_pkg::*; #(
  parameter int AUTO_CYC = AUTO_DEF_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // comparator outputs
  input  wire logic [5:0]  ana_cmp,
  input  wire logic [15:0] dig_in,
  // measured amplitude of the source
  input  wire logic [15:0] amp_max_mv,
  input  wire logic [15:0] amp_min_mv,
  // acquisition control
  output logic             trig_out,
  output logic             auto_trig,
  output logic             running,
  // front-end settings
  output logic [15:0]      level_mv,
  output logic [15:0]      thresh_mv,
  output logic [2:0]       couple_sel
);

  localparam logic [27:0] AUTO_LAST = 28'(AUTO_CYC - 1);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // settings registers
  // ----------------------------------------
  ctrl_t       ctrl_r, ctrl_nxt;
  logic [27:0] hold_r, hold_nxt;
  logic [27:0] dly_r, dly_nxt;
  logic [15:0] nevt_r, nevt_nxt;
  logic [27:0] pwref_r, pwref_nxt;
  logic [15:0] level_r, level_nxt;
  logic [15:0] thr_r, thr_nxt;
  logic        cmd_wr, cmd_run, cmd_stop;
  logic [16:0] amp_sum;
  logic [15:0] half_lvl;

  assign cmd_wr   = wr && (addr == A_CMD);
  assign cmd_run  = cmd_wr && wdata[C_RUN];
  assign cmd_stop = cmd_wr && wdata[C_STOP];
  assign amp_sum  = {amp_max_mv[15], amp_max_mv} + {amp_min_mv[15], amp_min_mv};
  assign half_lvl = amp_sum[16:1];

  function automatic logic [15:0] preset_mv(input logic [2:0] p);
    case (p)
      3'h0:    return P_TTL;
      3'h1:    return P_CMOS50;
      3'h2:    return P_CMOS33;
      3'h3:    return P_CMOS25;
      3'h4:    return P_ECL;
      3'h5:    return P_PECL;
      default: return P_ZERO;
    endcase
  endfunction

  always_comb begin
    ctrl_nxt  = ctrl_r;
    hold_nxt  = hold_r;
    dly_nxt   = dly_r;
    nevt_nxt  = nevt_r;
    pwref_nxt = pwref_r;
    level_nxt = level_r;
    thr_nxt   = thr_r;
    if (wr) begin
      case (addr)
        A_CTRL: begin
          ctrl_nxt      = ctrl_t'(wdata);
          ctrl_nxt.rsvd = '0;
        end
        A_HOLD:  hold_nxt = clamp_t(wdata, HOLD_MIN_CYC);
        // R5 delay range
        A_DLY:   dly_nxt = clamp_t(wdata, T_MIN_CYC);
        // R6 count range
        A_EVT:   nevt_nxt = (wdata[15:0] == 16'h0) ? EVT_MIN : wdata[15:0];
        // R8 reference range
        A_PWREF: pwref_nxt = clamp_t(wdata, T_MIN_CYC);
        A_LEVEL: level_nxt = wdata[15:0];
        A_THR:   thr_nxt = wdata[15:0];
        A_CMD: begin
          // R4 holdoff minimum
          if (wdata[C_HOLD_MIN]) hold_nxt = HOLD_MIN_CYC;
          // R7 delay minimum
          if (wdata[C_DLY_MIN]) dly_nxt = T_MIN_CYC;
          // R12 level at half
          if (wdata[C_HALF]) level_nxt = half_lvl;
          // R10 logic preset
          if (wdata[C_PRESET]) thr_nxt = preset_mv(ctrl_r.preset);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_r  <= ctrl_t'(CTRL_RST);
      hold_r  <= HOLD_MIN_CYC;
      dly_r   <= T_MIN_CYC;
      nevt_r  <= EVT_MIN;
      pwref_r <= T_MIN_CYC;
      level_r <= LEVEL_RST;
      thr_r   <= P_TTL;
    end else begin
      ctrl_r  <= ctrl_nxt;
      hold_r  <= hold_nxt;
      dly_r   <= dly_nxt;
      nevt_r  <= nevt_nxt;
      pwref_r <= pwref_nxt;
      level_r <= level_nxt;
      thr_r   <= thr_nxt;
    end
  end

  // ----------------------------------------
  // source pick and event detection
  // ----------------------------------------
  logic src_lvl, edge_ev, pw_ev, evt;

  always_comb begin
    if (is_dig(ctrl_r.src))   src_lvl = dig_in[ctrl_r.src[3:0]];
    else if (ctrl_r.src < 5'h06) src_lvl = ana_cmp[ctrl_r.src[2:0]];
    else                      src_lvl = 1'b0;
  end

  edge_pick u_edge (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .lvl   (src_lvl),
    .slope (ctrl_r.slope),
    .fire  (edge_ev)
  );

  pulse_width u_pw (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .lvl   (src_lvl),
    .pos   (ctrl_r.pw_pos),
    .cond  (ctrl_r.pw_cond),
    .refw  (pwref_r),
    .fire  (pw_ev)
  );

  assign evt = ctrl_r.pw_en ? pw_ev : edge_ev;

  // ----------------------------------------
  // trigger sequencing
  // ----------------------------------------
  st_t         st_r, st_nxt;
  logic [27:0] cnt_r, cnt_nxt;
  logic [15:0] ecnt_r, ecnt_nxt;
  logic        fire, auto_fire;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    ecnt_nxt  = ecnt_r;
    fire      = 1'b0;
    auto_fire = 1'b0;
    case (st_r)
      ST_STOP: begin
        if (cmd_run) begin
          st_nxt  = ST_ARMED;
          cnt_nxt = '0;
        end
      end
      ST_ARMED: begin
        if (evt) begin
          if (!ctrl_r.dly_en) begin
            fire = 1'b1;
          end else if (ctrl_r.dly_evt) begin
            st_nxt   = ST_DLY_E;
            ecnt_nxt = '0;
          end else begin
            st_nxt  = ST_DLY_T;
            cnt_nxt = '0;
          end
        // R2 internal trigger
        end else if (ctrl_r.mode == MODE_AUTO) begin
          if (cnt_r >= AUTO_LAST) begin
            fire      = 1'b1;
            auto_fire = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 28'h1;
          end
        end
        // R13 normal waits; no timer
      end
      // R5 wait delay time
      ST_DLY_T: begin
        if (cnt_r >= dly_r - 28'h1) fire = 1'b1;
        else cnt_nxt = cnt_r + 28'h1;
      end
      // R6 count events
      ST_DLY_E: begin
        if (evt) begin
          if (ecnt_r >= nevt_r - 16'h1) fire = 1'b1;
          else ecnt_nxt = ecnt_r + 16'h1;
        end
      end
      // R14 events ignored here
      ST_HOLD: begin
        if (cnt_r >= hold_r - 28'h1) begin
          st_nxt  = ST_ARMED;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 28'h1;
        end
      end
      default: st_nxt = ST_STOP;
    endcase
    if (fire) begin
      cnt_nxt = '0;
      // R3 single stops
      st_nxt = (ctrl_r.mode == MODE_SINGLE) ? ST_STOP : ST_HOLD;
    end
    // stop wins so software can always halt a pending delay
    if (cmd_stop) begin
      st_nxt    = ST_STOP;
      fire      = 1'b0;
      auto_fire = 1'b0;
    end
  end

  // ----------------------------------------
  // outputs and status
  // ----------------------------------------
  logic        trig_r, auto_r, run_r;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [2:0]  cpl_r, cpl_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    tcnt_nxt = tcnt_r + {15'h0, fire};
    cpl_nxt  = ctrl_r.coupling;
    // R11 digital forces dc
    if (is_dig(ctrl_r.src) && (cpl_nxt == CPL_AC || cpl_nxt == CPL_HF ||
        cpl_nxt == CPL_LF)) cpl_nxt = CPL_DC;
    rdata_nxt = 32'h0;
    if (rd) begin
      case (addr)
        A_CTRL:  rdata_nxt = 32'(ctrl_r);
        A_HOLD:  rdata_nxt = {4'h0, hold_r};
        A_DLY:   rdata_nxt = {4'h0, dly_r};
        A_EVT:   rdata_nxt = {16'h0, nevt_r};
        A_PWREF: rdata_nxt = {4'h0, pwref_r};
        A_LEVEL: rdata_nxt = {16'h0, level_r};
        A_THR:   rdata_nxt = {16'h0, thr_r};
        A_STAT:  rdata_nxt = {tcnt_r, 12'h0, run_r, st_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r    <= ST_STOP;
      cnt_r   <= 28'h0;
      ecnt_r  <= 16'h0;
      trig_r  <= 1'b0;
      auto_r  <= 1'b0;
      run_r   <= 1'b0;
      tcnt_r  <= 16'h0;
      cpl_r   <= 3'h0;
      rdata_r <= 32'h0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      ecnt_r  <= ecnt_nxt;
      trig_r  <= fire;
      auto_r  <= auto_fire;
      run_r   <= st_nxt != ST_STOP;
      tcnt_r  <= tcnt_nxt;
      cpl_r   <= cpl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign trig_out   = trig_r;
  assign auto_trig  = auto_r;
  assign running    = run_r;
  assign level_mv   = level_r;
  assign thresh_mv  = thr_r;
  assign couple_sel = cpl_r;
  assign rdata      = rdata_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_auto_due;
    st_r == ST_ARMED && ctrl_r.mode == MODE_AUTO && !evt && cnt_r >= AUTO_LAST;
  endsequence

  sequence s_single_fire;
    trig_r && $past(ctrl_r.mode) == MODE_SINGLE;
  endsequence

  AST_AUTO_FIRE: assert property ((s_auto_due ##0 !cmd_stop) |=> trig_out && auto_trig) // R2
    else $error("auto timeout gave no trigger");

  AST_SINGLE_STOP: assert property (s_single_fire |-> !running ##1 (!running || $past(cmd_run))) // R3
    else $error("single capture did not stop");

  AST_HOLD_MIN: assert property (cmd_wr && wdata[C_HOLD_MIN] |=> hold_r == HOLD_MIN_CYC) // R4
    else $error("holdoff minimum not loaded");

  AST_DLY_RANGE: assert property (dly_r >= T_MIN_CYC && dly_r <= T_MAX_CYC) // R5
    else $error("delay time out of range");

  AST_EVT_LAST: assert property (st_r == ST_DLY_E && evt && ecnt_r == nevt_r - 16'h1 // R6
    && !cmd_stop |=> trig_out)
    else $error("last delay event gave no trigger");

  AST_DLY_MIN: assert property (cmd_wr && wdata[C_DLY_MIN] |=> dly_r == T_MIN_CYC) // R7
    else $error("delay minimum not loaded");

  AST_PW_RANGE: assert property (pwref_r >= T_MIN_CYC && pwref_r <= T_MAX_CYC) // R8
    else $error("width reference out of range");

  AST_PRESET_TTL: assert property (cmd_wr && wdata[C_PRESET] && ctrl_r.preset == 3'h0 // R10
    |=> thresh_mv == P_TTL)
    else $error("ttl preset not loaded");

  AST_DIG_CPL: assert property (is_dig(ctrl_r.src) |=> couple_sel != CPL_AC // R11
    && couple_sel != CPL_HF && couple_sel != CPL_LF)
    else $error("filter coupling on digital source");

  AST_HALF: assert property (cmd_wr && wdata[C_HALF] |=> level_mv == $past(half_lvl)) // R12
    else $error("level not set to half amplitude");

  AST_NORM_NOAUTO: assert property (ctrl_r.mode == MODE_NORMAL && st_r == ST_ARMED // R13
    && !evt |=> !trig_out && !auto_trig)
    else $error("internal trigger in normal mode");

  AST_HOLD_IGN: assert property (st_r == ST_HOLD && cnt_r < hold_r - 28'h1 // R14
    |=> st_r != ST_ARMED && !trig_out)
    else $error("holdoff left early");

endmodule

// ---- sim/probe_src.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// probed inputs: one pulse at a time on a chosen line
// ----------------------------------------
module probe_src (
  // clock
  input  wire logic        clk,
  // pulse request from the bench
  input  wire logic        go,
  input  wire logic [4:0]  sel,
  input  wire logic [7:0]  len,
  // comparator levels
  output logic [5:0]       ana_cmp,
  output logic [15:0]      dig_in
);
  logic [7:0] left_r = 8'h00;

  // the line stays high for exactly len cycles, so widths are exact
  always_ff @(posedge clk) begin
    if (go) begin
      left_r <= len;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end

  // idle lines sit low, as a quiet probe would read below threshold
  always_comb begin
    ana_cmp = 6'h00;
    dig_in  = 16'h0000;
    if (left_r != 8'h00 && sel[4]) begin
      dig_in[sel[3:0]] = 1'b1;
    end else if (left_r != 8'h00 && sel < 5'd6) begin
      ana_cmp[sel[2:0]] = 1'b1;
    end
  end
endmodule

// ---- sim/scope_trigger_qualifier_tb_top.sv ----
`timescale 1ns/10ps
module scope_trigger_qualifier_tb_top import trig_pkg::*;;
  logic        clk        = 1'b0;
  logic        rst_n      = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [15:0] amp_max_mv = 16'h0000;
  logic [15:0] amp_min_mv = 16'h0000;
  logic        go         = 1'b0;
  logic [4:0]  sel        = 5'h00;
  logic [7:0]  len        = 8'h01;
  logic [31:0] rdata;
  logic [5:0]  ana_cmp;
  logic [15:0] dig_in;
  logic [15:0] level_mv;
  logic [15:0] thresh_mv;
  logic [2:0]  couple_sel;
  logic        trig_out;
  logic        auto_trig;
  logic        running;
  int          errors     = 0;
  int          tests_run  = 0;
  int          trig_cnt   = 0;
  int          auto_cnt   = 0;
  int          c0;
  int          n;
  int          mid[4]     = '{1, 0, 1, 0};
  int          fin[4]     = '{1, 1, 2, 0};
  logic [7:0]  pw_len[3]  = '{8'h03, 8'h05, 8'h08};
  logic [2:0]  pw_exp[4]  = '{3'b100, 3'b001, 3'b010, 3'b101};
  logic [15:0] thr[7]     = '{P_TTL, P_CMOS50, P_CMOS33, P_CMOS25, P_ECL, P_PECL, P_ZERO};
  logic [31:0] cpl_ctrl[5] = '{32'h0000c000, 32'h00014000, 32'h0001c000,
                               32'h00024000, 32'h00008000};
  logic [31:0] cpl_exp[5]  = '{32'h0, 32'h0, 32'h0, 32'h4, 32'h1};

  always #25 clk = ~clk;

  // counted on the falling edge, away from the registered outputs
  always @(negedge clk) begin
    if (trig_out === 1'b1) trig_cnt++;
    if (auto_trig === 1'b1) auto_cnt++;
  end

  // ----------------------------------------
  // design and probe model
  // ----------------------------------------
  trig_qual #(.AUTO_CYC(20)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ana_cmp(ana_cmp), .dig_in(dig_in), .amp_max_mv(amp_max_mv),
    .amp_min_mv(amp_min_mv), .trig_out(trig_out), .auto_trig(auto_trig),
    .running(running), .level_mv(level_mv), .thresh_mv(thresh_mv),
    .couple_sel(couple_sel)
  );

  probe_src probe (
    .clk(clk), .go(go), .sel(sel), .len(len), .ana_cmp(ana_cmp), .dig_in(dig_in)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the gap edge keeps a strobe from being set twice in one time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask

  task automatic setup(input logic [31:0] ctrl);
    wr_reg(A_CMD, 32'h2);
    wr_reg(A_CTRL, ctrl);
    wr_reg(A_CMD, 32'h1);
    repeat (2) @(posedge clk);
    c0 = trig_cnt;
  endtask

  task automatic pls(input logic [4:0] s, input logic [7:0] l);
    sel <= s;
    len <= l;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input logic [4:0] s, input logic [7:0] l);
    pls(s, l);
    repeat (int'(l) + 6) @(posedge clk);
  endtask

  task automatic wait_trig(input int lim, input logic e_auto);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (trig_out !== 1'b1 && n < lim);
    if (trig_out !== 1'b1) begin
      errors++;
      close_out();
    end
    chk(32'(auto_trig), 32'(e_auto));
    @(posedge clk);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(A_CTRL, CTRL_RST);
    rd_chk(A_HOLD, 32'h2);
    rd_chk(A_DLY, 32'h1);
    rd_chk(A_EVT, 32'h1);
    rd_chk(A_PWREF, 32'h1);
    rd_chk(8'h24, 32'h0);
    rd_chk(A_CMD, 32'h0);
    chk(32'(thresh_mv), 32'(P_TTL));
    chk(32'(running), 32'h0);
    wr_reg(A_HOLD, 32'd500);
    rd_chk(A_HOLD, 32'd500);
    wr_reg(A_CMD, 32'h4);
    rd_chk(A_HOLD, 32'h2);
    wr_reg(A_DLY, 32'd500);
    wr_reg(A_CMD, 32'h8);
    rd_chk(A_DLY, 32'h1);
    wr_reg(A_PWREF, 32'h0);
    rd_chk(A_PWREF, 32'h1);
    wr_reg(A_EVT, 32'h0);
    rd_chk(A_EVT, 32'h1);
    // normal mode on a digital line: silence, then one real event
    setup(32'h1 | (32'd16 << 10));
    repeat (60) @(posedge clk);
    chk(trig_cnt - c0, 0);
    pulse(5'd16, 8'd4);
    chk(trig_cnt - c0, 1);
    chk(auto_cnt, 0);
    chk(32'(running), 32'h1);
    for (int s = 0; s < 4; s++) begin
      setup(32'h1 | (s << 2));
      pls(5'd0, 8'd30);
      repeat (10) @(posedge clk);
      chk(trig_cnt - c0, mid[s]);
      repeat (30) @(posedge clk);
      chk(trig_cnt - c0, fin[s]);
    end
    wr_reg(A_HOLD, 32'd40);
    setup(32'h9);
    pulse(5'd0, 8'd5);
    chk(trig_cnt - c0, 1);
    repeat (40) @(posedge clk);
    pulse(5'd0, 8'd5);
    chk(trig_cnt - c0, 2);
    wr_reg(A_CMD, 32'h4);
    setup(32'h0);
    wait_trig(40, 1'b1);
    wait_trig(40, 1'b1);
    wr_reg(A_DLY, 32'd30);
    setup(32'h11);
    pulse(5'd0, 8'd2);
    repeat (17) @(posedge clk);
    chk(trig_cnt - c0, 0);
    wait_trig(20, 1'b0);
    chk(n, 32'd6);
    wr_reg(A_EVT, 32'h2);
    setup(32'h31);
    pulse(5'd0, 8'd3);
    pulse(5'd0, 8'd3);
    chk(trig_cnt - c0, 0);
    pulse(5'd0, 8'd3);
    chk(trig_cnt - c0, 1);
    setup(32'h2);
    pulse(5'd0, 8'd3);
    chk(trig_cnt - c0, 1);
    chk(32'(running), 32'h0);
    pulse(5'd0, 8'd3);
    chk(trig_cnt - c0, 1);
    wr_reg(A_CMD, 32'h1);
    pulse(5'd0, 8'd3);
    chk(trig_cnt - c0, 2);
    wr_reg(A_PWREF, 32'd5);
    for (int c = 0; c < 4; c++) begin
      setup(32'h241 | (c << 7));
      for (int i = 0; i < 3; i++) begin
        c0 = trig_cnt;
        pulse(5'd0, pw_len[i]);
        chk(trig_cnt - c0, 32'(pw_exp[c][i]));
      end
    end
    wr_reg(A_CMD, 32'h2);
    for (int p = 0; p < 7; p++) begin
      wr_reg(A_CTRL, p << 18);
      wr_reg(A_CMD, 32'h20);
      @(negedge clk);
      chk(32'(thresh_mv), 32'(thr[p]));
      @(posedge clk);
    end
    for (int k = 0; k < 5; k++) begin
      wr_reg(A_CTRL, cpl_ctrl[k]);
      rd_chk(A_CTRL, cpl_ctrl[k]);
      @(negedge clk);
      chk(32'(couple_sel), cpl_exp[k]);
      @(posedge clk);
    end
    amp_max_mv <= 16'd1000;
    amp_min_mv <= 16'hff38;
    wr_reg(A_CMD, 32'h10);
    @(negedge clk);
    chk(32'(level_mv), 32'h190);
    @(posedge clk);
    rd_chk(A_LEVEL, 32'h190);
    rd_chk(A_STAT, {trig_cnt[15:0], 16'h0});
    close_out();
  end
endmodule
